// ===== verilog/ppo_core.sv
// Priority ordering and deadlock avoidance for one packet link port.
// Assumes link logic reports accept or retry for each offered packet.
`timescale 1ns/1ps
`default_nettype none
module ppo_core (
	// Clock and reset
	input  wire logic                        SYS_CLK,
	input  wire logic                        RST,
	// Mode
	input  wire logic                        MODE_SWITCH,
	input  wire logic                        MODE_PROMOTE,
	// Transmit intake from transport layer
	input  wire logic                        TX_IN_VALID,
	output logic                             TX_IN_READY,
	input  wire logic [ppo_pkg::PRIO_W-1:0]  TX_IN_PRIO,
	input  wire logic                        TX_IN_IS_RESP,
	input  wire logic                        TX_IN_NEED_RESP,
	input  wire logic [ppo_pkg::PRIO_W-1:0]  TX_IN_REQ_PRIO,
	input  wire logic [ppo_pkg::SRC_W-1:0]   TX_IN_SRC,
	input  wire logic [ppo_pkg::DST_W-1:0]   TX_IN_DST,
	input  wire logic [ppo_pkg::FTYPE_W-1:0] TX_IN_FTYPE,
	input  wire logic [ppo_pkg::TAG_W-1:0]   TX_IN_TAG,
	// Transmit offer to link
	output logic                             TX_OUT_VALID,
	output logic      [ppo_pkg::PRIO_W-1:0]  TX_OUT_PRIO,
	output logic      [ppo_pkg::SRC_W-1:0]   TX_OUT_SRC,
	output logic      [ppo_pkg::DST_W-1:0]   TX_OUT_DST,
	output logic      [ppo_pkg::FTYPE_W-1:0] TX_OUT_FTYPE,
	output logic      [ppo_pkg::TAG_W-1:0]   TX_OUT_TAG,
	output logic      [ppo_pkg::PORT_W-1:0]  TX_OUT_PORT,
	input  wire logic                        TX_ACCEPT,
	input  wire logic                        TX_RETRY,
	// Receive from link
	input  wire logic                        RX_VALID,
	input  wire logic                        RX_ERR_FREE,
	input  wire logic [ppo_pkg::PRIO_W-1:0]  RX_PRIO,
	input  wire logic [ppo_pkg::SRC_W-1:0]   RX_SRC,
	input  wire logic [ppo_pkg::DST_W-1:0]   RX_DST,
	input  wire logic [ppo_pkg::FTYPE_W-1:0] RX_FTYPE,
	input  wire logic [ppo_pkg::TAG_W-1:0]   RX_TAG,
	output logic                             RX_ACK,
	output logic                             RX_NAK_RETRY,
	// Receive delivery to transport layer
	output logic                             RX_OUT_VALID,
	input  wire logic                        RX_OUT_READY,
	output logic      [ppo_pkg::PRIO_W-1:0]  RX_OUT_PRIO,
	output logic      [ppo_pkg::SRC_W-1:0]   RX_OUT_SRC,
	output logic      [ppo_pkg::DST_W-1:0]   RX_OUT_DST,
	output logic      [ppo_pkg::FTYPE_W-1:0] RX_OUT_FTYPE,
	output logic      [ppo_pkg::TAG_W-1:0]   RX_OUT_TAG
);
	import ppo_pkg::*;

	// Transmit slot state
	logic                sv_r    [TX_SLOTS];
	logic                sv_nxt  [TX_SLOTS];
	logic                sr_r    [TX_SLOTS];
	logic                sr_nxt  [TX_SLOTS];
	logic [PRIO_W-1:0]   sp_r    [TX_SLOTS];
	logic [PRIO_W-1:0]   sp_nxt  [TX_SLOTS];
	logic [SEQ_W-1:0]    sq_r    [TX_SLOTS];
	logic [SEQ_W-1:0]    sq_nxt  [TX_SLOTS];
	logic [DESC_W-1:0]   sd_r    [TX_SLOTS];
	logic [DESC_W-1:0]   sd_nxt  [TX_SLOTS];
	logic [SEQ_W-1:0]    seq_r;
	logic [SEQ_W-1:0]    seq_nxt;
	ppo_tx_state_t       txs_r;
	ppo_tx_state_t       txs_nxt;
	logic [TX_IDX_W-1:0] cur_r;
	logic [TX_IDX_W-1:0] cur_nxt;
	logic                in_rdy_r;
	logic                in_rdy_nxt;
	logic                out_v_r;
	logic                out_v_nxt;
	logic [PRIO_W-1:0]   out_p_r;
	logic [PRIO_W-1:0]   out_p_nxt;
	logic [DESC_W-1:0]   out_d_r;
	logic [DESC_W-1:0]   out_d_nxt;
	logic [PORT_W-1:0]   out_port_r;
	logic [PORT_W-1:0]   out_port_nxt;

	// Transmit selection and intake helpers
	logic                sel_found;
	logic [TX_IDX_W-1:0] sel_idx;
	logic                free_found;
	logic [TX_IDX_W-1:0] free_idx;
	logic [PRIO_W-1:0]   in_prio;
	logic                take;
	logic [2:0]          req_cnt;
	logic [2:0]          free_cnt;
	logic                tx_done;

	// Highest unsigned priority wins, then lowest age rank
	// Ranks close up on each departure, so age never wraps however long a slot waits
	always_comb begin
		sel_found  = 1'b0;
		sel_idx    = IDX_ZERO;
		free_found = 1'b0;
		free_idx   = IDX_ZERO;
		for (int i = 0; i < TX_SLOTS; i++) begin
			if (sv_r[i] && (!sel_found || (sp_r[i] > sp_r[sel_idx]) ||
			    ((sp_r[i] == sp_r[sel_idx]) && (sq_r[i] < sq_r[sel_idx])))) begin
				sel_found = 1'b1;
				sel_idx   = i[TX_IDX_W-1:0];
			end
			if (!sv_r[i] && !free_found) begin
				free_found = 1'b1;
				free_idx   = i[TX_IDX_W-1:0];
			end
		end
	end

	// Priority given at intake
	always_comb begin
		in_prio = TX_IN_PRIO;
		if (!MODE_SWITCH) begin
			if (TX_IN_IS_RESP) begin
				if (TX_IN_REQ_PRIO == PRIO_TOP) begin
					in_prio = PRIO_TOP;
				end else if (TX_IN_PRIO <= TX_IN_REQ_PRIO) begin
					in_prio = TX_IN_REQ_PRIO + PRIO_STEP;
				end
			end else if (TX_IN_NEED_RESP && (TX_IN_PRIO > PRIO_REQ_MAX)) begin
				in_prio = PRIO_REQ_MAX;
			end
		end
	end

	assign take    = TX_IN_VALID && in_rdy_r;
	assign tx_done = (txs_r == PPO_TX_BUSY) && TX_ACCEPT;

	// Transmit next state
	always_comb begin
		for (int i = 0; i < TX_SLOTS; i++) begin
			sv_nxt[i] = sv_r[i];
			sr_nxt[i] = sr_r[i];
			sp_nxt[i] = sp_r[i];
			sq_nxt[i] = sq_r[i];
			sd_nxt[i] = sd_r[i];
			// Younger slots move up one rank when the accepted slot leaves
			if (tx_done && sv_r[i] && (sq_r[i] > sq_r[cur_r])) begin
				sq_nxt[i] = sq_r[i] - SEQ_ONE;
			end
		end
		// Held count doubles as the rank given to the next intake
		seq_nxt      = seq_r - (tx_done ? SEQ_ONE : '0);
		txs_nxt      = txs_r;
		cur_nxt      = cur_r;
		out_v_nxt    = out_v_r;
		out_p_nxt    = out_p_r;
		out_d_nxt    = out_d_r;
		out_port_nxt = out_port_r;
		if (take) begin
			sv_nxt[free_idx] = 1'b1;
			sr_nxt[free_idx] = TX_IN_IS_RESP;
			sp_nxt[free_idx] = in_prio;
			sq_nxt[free_idx] = seq_nxt;
			sd_nxt[free_idx] = {TX_IN_SRC, TX_IN_DST, TX_IN_FTYPE, TX_IN_TAG};
			seq_nxt          = seq_nxt + SEQ_ONE;
		end
		case (txs_r)
			PPO_TX_IDLE: begin
				if (sel_found) begin
					txs_nxt      = PPO_TX_BUSY;
					cur_nxt      = sel_idx;
					out_v_nxt    = 1'b1;
					out_p_nxt    = sp_r[sel_idx];
					out_d_nxt    = sd_r[sel_idx];
					// Routing key is the destination field alone
					out_port_nxt = sd_r[sel_idx][DST_LSB +: PORT_W];
				end
			end
			PPO_TX_BUSY: begin
				if (TX_ACCEPT) begin
					// Slot freed only on acceptance
					sv_nxt[cur_r] = 1'b0;
					txs_nxt       = PPO_TX_IDLE;
					out_v_nxt     = 1'b0;
				end else if (TX_RETRY) begin
					// One level per retry keeps promotion minimal
					if (!MODE_SWITCH && MODE_PROMOTE && sr_r[cur_r] &&
					    (sp_r[cur_r] != PRIO_TOP)) begin
						sp_nxt[cur_r] = sp_r[cur_r] + PRIO_STEP;
					end
					txs_nxt   = PPO_TX_IDLE;
					out_v_nxt = 1'b0;
				end
			end
			default: begin
				txs_nxt   = PPO_TX_IDLE;
				out_v_nxt = 1'b0;
			end
		endcase
	end

	// Intake ready for next cycle, from the updated slots
	always_comb begin
		req_cnt  = '0;
		free_cnt = '0;
		for (int i = 0; i < TX_SLOTS; i++) begin
			if (sv_nxt[i] && !sr_nxt[i]) begin
				req_cnt = req_cnt + 3'h1;
			end
			if (!sv_nxt[i]) begin
				free_cnt = free_cnt + 3'h1;
			end
		end
		// Switch forwards no responses of its own; only end points hold a slot back
		in_rdy_nxt = (free_cnt != 3'h0) &&
		             (MODE_SWITCH || TX_IN_IS_RESP || (req_cnt < REQ_LIMIT));
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			for (int i = 0; i < TX_SLOTS; i++) begin
				sv_r[i] <= 1'b0;
				sr_r[i] <= 1'b0;
				sp_r[i] <= '0;
				sq_r[i] <= '0;
				sd_r[i] <= '0;
			end
			seq_r      <= '0;
			txs_r      <= PPO_TX_IDLE;
			cur_r      <= IDX_ZERO;
			in_rdy_r   <= 1'b0;
			out_v_r    <= 1'b0;
			out_p_r    <= '0;
			out_d_r    <= '0;
			out_port_r <= '0;
		end else begin
			for (int i = 0; i < TX_SLOTS; i++) begin
				sv_r[i] <= sv_nxt[i];
				sr_r[i] <= sr_nxt[i];
				sp_r[i] <= sp_nxt[i];
				sq_r[i] <= sq_nxt[i];
				sd_r[i] <= sd_nxt[i];
			end
			seq_r      <= seq_nxt;
			txs_r      <= txs_nxt;
			cur_r      <= cur_nxt;
			in_rdy_r   <= in_rdy_nxt;
			out_v_r    <= out_v_nxt;
			out_p_r    <= out_p_nxt;
			out_d_r    <= out_d_nxt;
			out_port_r <= out_port_nxt;
		end
	end

	// Receive state
	logic [RX_CNT_W-1:0]  cnt_r;
	logic [RX_CNT_W-1:0]  cnt_nxt;
	logic [RX_ADDR_W-1:0] wp_r;
	logic [RX_ADDR_W-1:0] wp_nxt;
	logic [RX_ADDR_W-1:0] rp_r;
	logic [RX_ADDR_W-1:0] rp_nxt;
	logic [RX_CNT_W-1:0]  stored_r;
	logic [RX_CNT_W-1:0]  stored_nxt;
	logic                 pend_r;
	logic                 pend_nxt;
	logic                 ack_r;
	logic                 ack_nxt;
	logic                 nak_r;
	logic                 nak_nxt;
	logic                 ov_r;
	logic                 ov_nxt;
	logic [RXW_W-1:0]     ow_r;
	logic [RXW_W-1:0]     ow_nxt;
	logic                 room;
	logic                 acc;
	logic                 rd_go;
	logic                 dlv;
	logic [RXW_W-1:0]     mem_q;

	// Ladder: occupancy at most N admits priority N, so each level keeps a buffer
	assign room  = ({1'b0, RX_PRIO} >= cnt_r) && (cnt_r < RXC_FULL);
	// Decision looks at input space only, never at transmit congestion
	assign acc   = RX_VALID && RX_ERR_FREE && room;
	assign dlv   = ov_r && RX_OUT_READY;
	assign rd_go = (stored_r != '0) && !pend_r && !ov_r;

	always_comb begin
		cnt_nxt    = cnt_r;
		wp_nxt     = wp_r;
		rp_nxt     = rp_r;
		stored_nxt = stored_r;
		pend_nxt   = 1'b0;
		ov_nxt     = ov_r;
		ow_nxt     = ow_r;
		ack_nxt    = acc;
		// Errored packets belong to error recovery, not to a retry here
		nak_nxt    = RX_VALID && RX_ERR_FREE && !room;
		if (acc) begin
			wp_nxt = wp_r + RXA_ONE;
		end
		if (rd_go) begin
			rp_nxt   = rp_r + RXA_ONE;
			pend_nxt = 1'b1;
		end
		stored_nxt = stored_r + (acc ? RXC_ONE : '0) - (rd_go ? RXC_ONE : '0);
		// Count covers packets until handed upward
		cnt_nxt    = cnt_r + (acc ? RXC_ONE : '0) - (dlv ? RXC_ONE : '0);
		if (pend_r) begin
			ov_nxt = 1'b1;
			ow_nxt = mem_q;
		end else if (dlv) begin
			ov_nxt = 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			cnt_r    <= '0;
			wp_r     <= '0;
			rp_r     <= '0;
			stored_r <= '0;
			pend_r   <= 1'b0;
			ack_r    <= 1'b0;
			nak_r    <= 1'b0;
			ov_r     <= 1'b0;
			ow_r     <= '0;
		end else begin
			cnt_r    <= cnt_nxt;
			wp_r     <= wp_nxt;
			rp_r     <= rp_nxt;
			stored_r <= stored_nxt;
			pend_r   <= pend_nxt;
			ack_r    <= ack_nxt;
			nak_r    <= nak_nxt;
			ov_r     <= ov_nxt;
			ow_r     <= ow_nxt;
		end
	end

	ppo_mem u_rx_mem (
		.clk     (SYS_CLK),
		.wr_en   (acc),
		.wr_addr (wp_r),
		.wr_data ({RX_PRIO, RX_SRC, RX_DST, RX_FTYPE, RX_TAG}),
		.rd_en   (rd_go),
		.rd_addr (rp_r),
		.rd_data (mem_q)
	);

	// Outputs
	assign TX_IN_READY  = in_rdy_r;
	assign TX_OUT_VALID = out_v_r;
	assign TX_OUT_PRIO  = out_p_r;
	assign TX_OUT_SRC   = out_d_r[SRC_LSB +: SRC_W];
	assign TX_OUT_DST   = out_d_r[DST_LSB +: DST_W];
	assign TX_OUT_FTYPE = out_d_r[FTYPE_LSB +: FTYPE_W];
	assign TX_OUT_TAG   = out_d_r[TAG_LSB +: TAG_W];
	assign TX_OUT_PORT  = out_port_r;
	assign RX_ACK       = ack_r;
	assign RX_NAK_RETRY = nak_r;
	assign RX_OUT_VALID = ov_r;
	assign RX_OUT_PRIO  = ow_r[DESC_W +: PRIO_W];
	assign RX_OUT_SRC   = ow_r[SRC_LSB +: SRC_W];
	assign RX_OUT_DST   = ow_r[DST_LSB +: DST_W];
	assign RX_OUT_FTYPE = ow_r[FTYPE_LSB +: FTYPE_W];
	assign RX_OUT_TAG   = ow_r[TAG_LSB +: TAG_W];

endmodule : ppo_core
`default_nettype wire

// ===== verilog/ppo_pkg.sv
// Constants and types shared by the packet priority ordering block.
// Assumes a single 100 MHz clock domain and a two-bit packet priority.
package ppo_pkg;

	localparam int PRIO_W    = 2;
	localparam int SRC_W     = 8;
	localparam int DST_W     = 8;
	localparam int FTYPE_W   = 4;
	localparam int TAG_W     = 8;
	localparam int PORT_W    = 2;
	localparam int TX_SLOTS  = 4;
	localparam int TX_IDX_W  = 2;
	localparam int SEQ_W     = 3;
	localparam int RX_DEPTH  = 4;
	localparam int RX_ADDR_W = 2;
	localparam int RX_CNT_W  = 3;

	// Descriptor layout {src, dst, ftype, tag}
	localparam int DESC_W    = SRC_W + DST_W + FTYPE_W + TAG_W;
	localparam int TAG_LSB   = 0;
	localparam int FTYPE_LSB = TAG_LSB + TAG_W;
	localparam int DST_LSB   = FTYPE_LSB + FTYPE_W;
	localparam int SRC_LSB   = DST_LSB + DST_W;
	// Receive memory word {prio, descriptor}
	localparam int RXW_W     = PRIO_W + DESC_W;

	localparam logic [PRIO_W-1:0]   PRIO_TOP    = 2'h3;
	localparam logic [PRIO_W-1:0]   PRIO_REQ_MAX = 2'h2;
	localparam logic [PRIO_W-1:0]   PRIO_STEP   = 2'h1;
	localparam logic [FTYPE_W-1:0]  FTYPE_MAINT = 4'h8;
	localparam logic [SEQ_W-1:0]    SEQ_ONE     = 3'h1;
	localparam logic [TX_IDX_W-1:0] IDX_ZERO    = 2'h0;
	localparam logic [RX_ADDR_W-1:0] RXA_ONE    = 2'h1;
	localparam logic [RX_CNT_W-1:0] RXC_ONE     = 3'h1;
	localparam logic [RX_CNT_W-1:0] RXC_FULL    = 3'h4;
	localparam logic [2:0]          REQ_LIMIT   = 3'h3;

	typedef enum logic [0:0] {
		PPO_TX_IDLE,
		PPO_TX_BUSY
	} ppo_tx_state_t;

endpackage : ppo_pkg

// ===== verilog/ppo_mem.sv
// Small receive buffer memory: one write port, one read port.
// Assumes the caller never reads and writes the same word in one cycle.
`timescale 1ns/1ps
`default_nettype none
module ppo_mem (
	// Clock
	input  wire logic                         clk,
	// Write side
	input  wire logic                         wr_en,
	input  wire logic [ppo_pkg::RX_ADDR_W-1:0] wr_addr,
	input  wire logic [ppo_pkg::RXW_W-1:0]    wr_data,
	// Read side
	input  wire logic                         rd_en,
	input  wire logic [ppo_pkg::RX_ADDR_W-1:0] rd_addr,
	output logic      [ppo_pkg::RXW_W-1:0]    rd_data
);
	import ppo_pkg::*;

	logic [RXW_W-1:0] mem_r [RX_DEPTH];
	logic [RXW_W-1:0] rd_data_r;

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem_r[wr_addr] <= wr_data;
		end
		if (rd_en) begin
			rd_data_r <= mem_r[rd_addr];
		end
	end

	assign rd_data = rd_data_r;

endmodule : ppo_mem
`default_nettype wire

// ===== tb/ppo_core_assertions.sv
// Port checker for the priority ordering core.
// Assumes SYS_CLK only and synchronous active-high RST.
`timescale 1ns/1ps
`default_nettype none
module ppo_core_chk (
	// Clock and reset
	input wire logic			SYS_CLK,
	input wire logic			RST,
	// Transmit side
	input wire logic			TX_IN_VALID,
	input wire logic			TX_IN_READY,
	input wire logic			TX_OUT_VALID,
	input wire logic [ppo_pkg::PRIO_W-1:0]	TX_OUT_PRIO,
	input wire logic [ppo_pkg::DST_W-1:0]	TX_OUT_DST,
	input wire logic [ppo_pkg::TAG_W-1:0]	TX_OUT_TAG,
	input wire logic [ppo_pkg::PORT_W-1:0]	TX_OUT_PORT,
	input wire logic			TX_ACCEPT,
	input wire logic			TX_RETRY,
	// Receive side
	input wire logic			RX_VALID,
	input wire logic			RX_ERR_FREE,
	input wire logic [ppo_pkg::PRIO_W-1:0]	RX_PRIO,
	input wire logic			RX_ACK,
	input wire logic			RX_NAK_RETRY,
	input wire logic			RX_OUT_VALID,
	input wire logic			RX_OUT_READY,
	input wire logic [ppo_pkg::TAG_W-1:0]	RX_OUT_TAG
);
	import ppo_pkg::*;
	// Shadow counts from port events only; no view of slot contents
	logic [RX_CNT_W-1:0]	occ_r, occ_nxt, held_r, held_nxt;
	always_comb begin
		occ_nxt = occ_r + RX_CNT_W'(RX_ACK) - RX_CNT_W'(RX_OUT_VALID && RX_OUT_READY);
		held_nxt = held_r + RX_CNT_W'(TX_IN_VALID && TX_IN_READY)
			- RX_CNT_W'(TX_OUT_VALID && TX_ACCEPT);
	end
	always_ff @(posedge SYS_CLK) begin
		occ_r <= RST ? '0 : occ_nxt;
		held_r <= RST ? '0 : held_nxt;
	end
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	rx_answer_a: assert property (RX_VALID && RX_ERR_FREE |=> RX_ACK != RX_NAK_RETRY)
		else $error("received packet without single answer");
	rx_silent_a: assert property (!(RX_VALID && RX_ERR_FREE) |=> !RX_ACK && !RX_NAK_RETRY)
		else $error("answer without error-free packet");
	rx_ladder_a: assert property (RX_VALID && RX_ERR_FREE
		&& (occ_r + RX_CNT_W'(RX_ACK)) <= RX_CNT_W'(RX_PRIO) |=> RX_ACK)
		else $error("packet retried with room at its priority");
	rx_deliver_a: assert property (RX_ACK && occ_r == '0 && !RX_OUT_VALID
		|-> ##[2:4] RX_OUT_VALID) else $error("accepted packet not delivered");
	rx_hold_a: assert property (RX_OUT_VALID && !RX_OUT_READY
		|=> RX_OUT_VALID && $stable(RX_OUT_TAG)) else $error("delivery dropped early");
	tx_hold_a: assert property (TX_OUT_VALID && !TX_ACCEPT && !TX_RETRY
		|=> TX_OUT_VALID && $stable(TX_OUT_PRIO) && $stable(TX_OUT_TAG))
		else $error("offer changed before answer");
	tx_release_a: assert property (TX_OUT_VALID && (TX_ACCEPT || TX_RETRY) |=> !TX_OUT_VALID)
		else $error("offer kept after answer");
	tx_route_a: assert property (TX_OUT_VALID |-> TX_OUT_PORT == TX_OUT_DST[1:0])
		else $error("output port not from destination");
	tx_slots_a: assert property (held_r == RXC_FULL |-> !(TX_IN_VALID && TX_IN_READY))
		else $error("intake taken with all slots held");
endmodule : ppo_core_chk
bind ppo_core ppo_core_chk chk_i (.SYS_CLK, .RST, .TX_IN_VALID, .TX_IN_READY, .TX_OUT_VALID,
	.TX_OUT_PRIO, .TX_OUT_DST, .TX_OUT_TAG, .TX_OUT_PORT, .TX_ACCEPT, .TX_RETRY, .RX_VALID,
	.RX_ERR_FREE, .RX_PRIO, .RX_ACK, .RX_NAK_RETRY, .RX_OUT_VALID, .RX_OUT_READY, .RX_OUT_TAG);
`default_nettype wire

// ===== tb/ppo_link_model.sv
// Link partner: answers each offer with retry or accept after a delay.
// Assumes offers hold until answered and drop the cycle after.
`timescale 1ns/1ps
`default_nettype none
module ppo_link_model (
	// Clock and reset
	input wire logic	clk,
	input wire logic	rst,
	// Offer and behaviour
	input wire logic	offer_valid,
	input wire logic [7:0]	delay,
	input wire logic [1:0]	retry_n,
	// Answer pulses
	output logic		accept,
	output logic		retry
);
	logic [7:0]	wait_r;
	logic [1:0]	done_r;
	always_ff @(posedge clk) begin
		accept <= 1'b0;
		retry <= 1'b0;
		if (rst) begin
			wait_r <= 8'h00;
			done_r <= 2'h0;
		end else if (offer_valid && !accept && !retry) begin
			if (wait_r >= delay) begin
				wait_r <= 8'h00;
				// Retries first, so slow and refusing partners both appear
				if (done_r < retry_n) begin
					retry <= 1'b1;
					done_r <= done_r + 2'h1;
				end else begin
					accept <= 1'b1;
				end
			end else begin
				wait_r <= wait_r + 8'h01;
			end
		end
	end
endmodule : ppo_link_model
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the priority ordering core.
// Assumes the link model answers offers; transport sides driven here.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import ppo_pkg::*;
	logic			clk, rst, m_sw, m_pro, lk_clr, acc_e;
	logic			i_v, i_rdy, i_rsp, i_need, o_v, acc, rty;
	logic			r_v, r_ef, r_ack, r_nak, d_v, d_rdy;
	logic [PRIO_W-1:0]	i_p, i_rp, o_p, r_p, d_p;
	logic [SRC_W-1:0]	i_src, o_src, r_src, d_src;
	logic [DST_W-1:0]	i_dst, o_dst, r_dst, d_dst;
	logic [FTYPE_W-1:0]	i_ft, o_ft, r_ft, d_ft;
	logic [TAG_W-1:0]	i_tag, o_tag, r_tag, d_tag;
	logic [PORT_W-1:0]	o_port;
	logic [7:0]		lk_dly;
	logic [1:0]		lk_rn;
	logic [PRIO_W-1:0]	gp[$];
	logic [TAG_W-1:0]	gt[$];
	logic [RXW_W-1:0]	ew[$];
	int			mismatches, checked;
	ppo_core uut (.SYS_CLK(clk), .RST(rst), .MODE_SWITCH(m_sw), .MODE_PROMOTE(m_pro),
		.TX_IN_VALID(i_v), .TX_IN_READY(i_rdy), .TX_IN_PRIO(i_p), .TX_IN_IS_RESP(i_rsp),
		.TX_IN_NEED_RESP(i_need), .TX_IN_REQ_PRIO(i_rp), .TX_IN_SRC(i_src),
		.TX_IN_DST(i_dst), .TX_IN_FTYPE(i_ft), .TX_IN_TAG(i_tag), .TX_OUT_VALID(o_v),
		.TX_OUT_PRIO(o_p), .TX_OUT_SRC(o_src), .TX_OUT_DST(o_dst), .TX_OUT_FTYPE(o_ft),
		.TX_OUT_TAG(o_tag), .TX_OUT_PORT(o_port), .TX_ACCEPT(acc), .TX_RETRY(rty),
		.RX_VALID(r_v), .RX_ERR_FREE(r_ef), .RX_PRIO(r_p), .RX_SRC(r_src), .RX_DST(r_dst),
		.RX_FTYPE(r_ft), .RX_TAG(r_tag), .RX_ACK(r_ack), .RX_NAK_RETRY(r_nak),
		.RX_OUT_VALID(d_v), .RX_OUT_READY(d_rdy), .RX_OUT_PRIO(d_p), .RX_OUT_SRC(d_src),
		.RX_OUT_DST(d_dst), .RX_OUT_FTYPE(d_ft), .RX_OUT_TAG(d_tag));
	ppo_link_model link (.clk(clk), .rst(rst || lk_clr), .offer_valid(o_v), .delay(lk_dly),
		.retry_n(lk_rn), .accept(acc), .retry(rty));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Accepted offers, read before this edge's updates land
	always @(posedge clk) begin
		if (o_v && acc) begin
			gp.push_back(o_p);
			gt.push_back(o_tag);
			chk("tx ids", o_dst ^ o_tag, o_src);
			chk("tx ftype", 8'(i_ft), 8'(o_ft));
		end
	end
	task automatic tick;
		@(posedge clk);
		#1;
	endtask : tick
	task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
		checked++;
		if (exp !== got) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic put(logic [1:0] p, logic rs, logic nd, logic [1:0] rp, logic [7:0] tg);
		i_v = 1'b1;
		i_p = p;
		i_rsp = rs;
		i_need = nd;
		i_rp = rp;
		i_tag = tg;
		i_dst = 8'($urandom);
		i_src = i_dst ^ tg;
	endtask : put
	task automatic take;
		for (int n = 0; i_rdy !== 1'b1 && n < 300; n++) tick;
		tick;
	endtask : take
	task automatic clear;
		lk_clr = 1'b1;
		tick;
		lk_clr = 1'b0;
		gp.delete();
		gt.delete();
	endtask : clear
	task automatic wait_n(int k);
		for (int n = 0; gt.size() < k && n < 2000; n++) tick;
		if (gt.size() < k) chk("accepted count", 8'(k), 8'(gt.size()));
	endtask : wait_n
	function automatic logic [1:0] ep(logic [1:0] p, logic rs, logic [1:0] rp);
		if (!rs)
			return (p == PRIO_TOP) ? PRIO_REQ_MAX : p;
		if (rp == PRIO_TOP)
			return PRIO_TOP;
		return (p > rp) ? p : rp + 2'h1;
	endfunction : ep
	task automatic stop_test;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		stop_test;
	end
	initial begin
		int i, k, p, occ;
		logic [1:0] pr[4];
		logic [RXW_W-1:0] w;
		{m_sw, m_pro, lk_clr, i_v, i_rsp, i_need, r_v, r_ef, d_rdy, acc_e} = '0;
		{i_p, i_rp, i_src, i_dst, i_ft, i_tag, r_p, r_src, r_dst, r_ft, r_tag} = '0;
		{lk_dly, lk_rn} = '0;
		rst = 1'b1;
		i = $urandom(95);
		repeat (20) tick;
		rst = 1'b0;
		repeat (2) tick;
		// Switch: oldest retried, then highest priority, oldest first
		m_sw = 1'b1;
		for (int r = 0; r < 2; r++) begin
			lk_rn = 2'h1;
			lk_dly = 8'h14;
			clear;
			i_ft = r ? FTYPE_MAINT : 4'h5;
			for (i = 0; i < 4; i++) begin
				pr[i] = 2'($urandom);
				put(pr[i], 1'($urandom), 1'($urandom), 2'($urandom), 8'(i));
				take;
			end
			i_v = 1'b0;
			wait_n(4);
			k = 0;
			for (p = 3; p >= 0; p--)
				for (i = 0; i < 4; i++)
					if (pr[i] == 2'(p)) begin
						chk("order tag", 8'(i), gt[k]);
						chk("switch prio", 8'(pr[i]), 8'(gp[k]));
						k++;
					end
		end
		// End point intake priorities, one packet at a time
		m_sw = 1'b0;
		lk_rn = 2'h0;
		lk_dly = 8'h00;
		for (i = 0; i < 8; i++) begin
			clear;
			p = (i < 4) ? $urandom_range(3) : i - 4;
			put(2'(p), i < 4, 1'b1, 2'(i), 8'(i));
			take;
			i_v = 1'b0;
			wait_n(1);
			chk("intake prio", 8'(ep(2'(p), i < 4, 2'(i))), 8'(gp[0]));
		end
		// Two retries: promoted only when enabled
		for (i = 0; i < 2; i++) begin
			m_pro = (i == 0);
			lk_rn = 2'h2;
			clear;
			put(2'h0, 1'b1, 1'b0, 2'h0, 8'h40);
			take;
			i_v = 1'b0;
			wait_n(1);
			chk("promoted prio", i ? 8'h01 : 8'h03, 8'(gp[0]));
		end
		// Stalled link: last slot kept for a response
		m_pro = 1'b0;
		lk_rn = 2'h0;
		lk_dly = 8'h96;
		clear;
		for (i = 0; i < 4; i++) begin
			put(2'h0, 1'b0, 1'b0, 2'h0, 8'(i));
			if (i < 3)
				take;
		end
		repeat (4) tick;
		chk("request ready", 8'h00, 8'(i_rdy));
		i_rsp = 1'b1;
		take;
		i_v = 1'b0;
		// Receive ladder while the link stays stalled
		occ = 0;
		for (i = 0; i < 10; i++) begin
			r_v = 1'b1;
			r_ef = (i != 4);
			r_p = 2'($urandom);
			r_tag = 8'(i);
			{r_src, r_dst, r_ft} = 20'($urandom);
			acc_e = r_ef && occ <= int'(r_p);
			if (acc_e) begin
				occ++;
				ew.push_back({r_p, r_src, r_dst, r_ft, r_tag});
			end
			tick;
			chk("rx accept", 8'(acc_e), 8'(r_ack));
			chk("rx retry", 8'(r_ef && !acc_e), 8'(r_nak));
		end
		r_v = 1'b0;
		d_rdy = 1'b1;
		while (ew.size() > 0) begin
			for (k = 0; d_v !== 1'b1 && k < 20; k++) tick;
			w = ew.pop_front();
			chk("rx order", w[TAG_LSB +: TAG_W], d_tag);
			chk("rx prio", 8'(w[DESC_W +: PRIO_W]), 8'(d_p));
			chk("rx src", w[SRC_LSB +: SRC_W], d_src);
			chk("rx dst", w[DST_LSB +: DST_W], d_dst);
			chk("rx ftype", 8'(w[FTYPE_LSB +: FTYPE_W]), 8'(d_ft));
			tick;
		end
		wait_n(4);
		chk("response first", 8'h03, gt[1]);
		chk("request order", 8'h01, gt[2]);
		chk("request order", 8'h02, gt[3]);
		// Mid-run reset must clear every offer and answer at once
		rst = 1'b1;
		tick;
		chk("reset outputs", 8'h00, 8'({o_v, o_p, d_v, r_ack, r_nak, i_rdy}));
		stop_test;
	end
endmodule : tb_top
`default_nettype wire
